// ===== etwb_front_end.sv
// etwb_front_end: slave side of the two-wire serial bus of a small eeprom
// assumes clock line and data line pins arrive asynchronously; memory core sits on CLK_SYS
`timescale 1ns/1ps
module etwb_front_end (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic WRITE_BUSY,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  input wire logic RX_READY,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic BUS_BUSY,
  output logic START_SEEN,
  output logic STOP_SEEN,
  output logic ADDRESSED,
  output logic READ_MODE
);

  // reset release
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // line conditioning, index 0 clock line, index 1 data line
  logic [1:0] pin_raw;
  logic [1:0] line_filt;

  assign pin_raw = {SDA_I, SCL_I};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      logic meta_reg;
      logic sync_reg;
      logic filt_reg;
      logic [etwb_pkg::SPIKE_W-1:0] cnt_reg;
      logic differs;
      logic accept;

      assign differs = sync_reg != filt_reg;
      assign accept = differs && (cnt_reg == etwb_pkg::SPIKE_CYC);

      always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg <= etwb_pkg::LINE_RESET;
          sync_reg <= etwb_pkg::LINE_RESET;
        end else begin
          meta_reg <= pin_raw[g];
          sync_reg <= meta_reg;
        end
      end

      // a change must persist longer than the spike width to pass
      always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
          filt_reg <= etwb_pkg::LINE_RESET;
          cnt_reg <= '0;
        end else if (!differs || accept) begin
          filt_reg <= sync_reg;
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end

      assign line_filt[g] = filt_reg;
    end
  endgenerate

  // bus conditions
  logic scl;
  logic sda;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl = line_filt[0];
  assign sda = line_filt[1];
  assign scl_rise = scl && !scl_d_reg;
  assign scl_fall = !scl && scl_d_reg;
  assign start_cond = scl && scl_d_reg && sda_d_reg && !sda;
  assign stop_cond = scl && scl_d_reg && !sda_d_reg && sda;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= etwb_pkg::LINE_RESET;
      sda_d_reg <= etwb_pkg::LINE_RESET;
    end else begin
      scl_d_reg <= scl;
      sda_d_reg <= sda;
    end
  end

  // protocol state
  etwb_pkg::etwb_state_e state_reg;
  etwb_pkg::etwb_state_e state_next;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_shift_reg;
  logic ack_reg;
  logic rw_reg;
  logic mack_reg;
  logic tx_ready_reg;
  logic addressed_reg;
  logic busy_reg;
  logic start_reg;
  logic stop_reg;

  logic active;
  logic byte_done;
  logic ack_done;
  logic ctrl_match;
  logic ack_ctrl;
  logic ack_data;
  logic ack_now;
  logic rx_room;
  logic push;
  logic tx_load_req;
  logic in_ack_slot;
  logic bit_end;
  logic rise_seen_reg;

  assign active = state_reg != etwb_pkg::ST_IDLE;
  // only a fall after a rise closes a bit; the fall that ends a Start does not
  assign bit_end = active && scl_fall && rise_seen_reg;
  assign byte_done = bit_end && (bit_cnt_reg == etwb_pkg::LAST_DATA_BIT);
  assign ack_done = bit_end && (bit_cnt_reg == etwb_pkg::ACK_SLOT);
  assign in_ack_slot = bit_cnt_reg == etwb_pkg::ACK_SLOT;
  assign ctrl_match = shift_reg[7:4] == etwb_pkg::CTRL_CODE;
  assign ack_ctrl = ctrl_match && !WRITE_BUSY;
  assign ack_data = !WRITE_BUSY && rx_room;
  assign ack_now = (state_reg == etwb_pkg::ST_CTRL) ? ack_ctrl :
                   (state_reg == etwb_pkg::ST_RX) ? ack_data : 1'b0;
  assign push = byte_done && (state_reg == etwb_pkg::ST_RX) && ack_data;
  // an acknowledged control read, or master ack low after a sent byte, asks for another byte
  assign tx_load_req = ack_done && (((state_reg == etwb_pkg::ST_CTRL) && ack_reg && rw_reg) ||
                                    ((state_reg == etwb_pkg::ST_TX) && !mack_reg));

  always_comb begin
    state_next = state_reg;
    if (stop_cond) begin
      state_next = etwb_pkg::ST_IDLE;
    end else if (start_cond) begin
      state_next = etwb_pkg::ST_CTRL;
    end else if (ack_done) begin
      unique case (state_reg)
        etwb_pkg::ST_CTRL: begin
          if (!ack_reg) begin
            state_next = etwb_pkg::ST_SKIP;
          end else if (rw_reg) begin
            state_next = etwb_pkg::ST_TX;
          end else begin
            state_next = etwb_pkg::ST_RX;
          end
        end
        etwb_pkg::ST_TX: begin
          state_next = mack_reg ? etwb_pkg::ST_SKIP : etwb_pkg::ST_TX;
        end
        etwb_pkg::ST_IDLE,
        etwb_pkg::ST_RX,
        etwb_pkg::ST_SKIP: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= etwb_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // one bit per clock pulse, ninth pulse is the acknowledge slot
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 4'h0;
      rise_seen_reg <= 1'b0;
    end else if (start_cond || stop_cond) begin
      bit_cnt_reg <= 4'h0;
      rise_seen_reg <= 1'b0;
    end else if (bit_end) begin
      bit_cnt_reg <= in_ack_slot ? 4'h0 : bit_cnt_reg + 4'h1;
    end else if (active && scl_rise) begin
      rise_seen_reg <= 1'b1;
    end
  end

  // sample once on each clock rise; a later change in the high phase is Start or Stop
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= etwb_pkg::BYTE_RESET;
      mack_reg <= 1'b1;
    end else if (active && scl_rise) begin
      if (in_ack_slot) begin
        mack_reg <= sda;
      end else begin
        shift_reg <= {shift_reg[6:0], sda};
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rw_reg <= 1'b0;
      addressed_reg <= 1'b0;
    end else if (start_cond || stop_cond) begin
      ack_reg <= 1'b0;
      addressed_reg <= 1'b0;
    end else if (byte_done) begin
      ack_reg <= ack_now;
      if (state_reg == etwb_pkg::ST_CTRL) begin
        rw_reg <= shift_reg[0];
        addressed_reg <= ack_ctrl;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      busy_reg <= start_cond ? 1'b1 : (stop_cond ? 1'b0 : busy_reg);
      start_reg <= start_cond;
      stop_reg <= stop_cond;
    end
  end

  // transmit byte fetch and shift
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready_reg <= 1'b0;
      tx_shift_reg <= etwb_pkg::IDLE_BYTE;
    end else begin
      tx_ready_reg <= tx_load_req;
      if (tx_ready_reg) begin
        tx_shift_reg <= TX_VALID ? TX_DATA : etwb_pkg::IDLE_BYTE;
      end else if (scl_fall && (state_reg == etwb_pkg::ST_TX) && (bit_cnt_reg < etwb_pkg::LAST_DATA_BIT)) begin
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
      end
    end
  end

  // output timing: line changes a fixed delay after each clock fall, or is released at once on Start or Stop
  logic [etwb_pkg::DLY_W-1:0] dly_cnt_reg;
  logic dly_run_reg;
  logic dly_done;
  logic want_low;
  logic sda_oe_reg;
  logic sda_o_reg;

  assign dly_done = dly_run_reg && (dly_cnt_reg == '0);
  assign want_low = in_ack_slot ? ack_reg :
                    ((state_reg == etwb_pkg::ST_TX) && !tx_shift_reg[7]);

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      dly_cnt_reg <= '0;
      dly_run_reg <= 1'b0;
    end else if (start_cond || stop_cond) begin
      dly_run_reg <= 1'b0;
    end else if (active && scl_fall) begin
      dly_cnt_reg <= etwb_pkg::OUT_DLY_CYC;
      dly_run_reg <= 1'b1;
    end else if (dly_done) begin
      dly_run_reg <= 1'b0;
    end else if (dly_run_reg) begin
      dly_cnt_reg <= dly_cnt_reg - 1'b1;
    end
  end

  // pull low or release only; the high level comes from the pull-up
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_reg <= 1'b0;
      sda_o_reg <= 1'b0;
    end else begin
      sda_o_reg <= 1'b0;
      if (start_cond || stop_cond) begin
        sda_oe_reg <= 1'b0;
      end else if (dly_done) begin
        sda_oe_reg <= want_low;
      end
    end
  end

  // two-entry receive buffer; full buffer withholds the acknowledge
  logic [7:0] ent0_reg;
  logic [7:0] ent1_reg;
  logic [1:0] buf_cnt_reg;
  logic [1:0] buf_cnt_next;
  logic rx_valid_reg;
  logic pop;
  logic wr_slot1;

  assign rx_room = buf_cnt_reg != etwb_pkg::BUF_FULL;
  assign pop = rx_valid_reg && RX_READY;
  assign buf_cnt_next = buf_cnt_reg + {1'b0, push} - {1'b0, pop};
  assign wr_slot1 = (buf_cnt_reg - {1'b0, pop}) != 2'h0;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      buf_cnt_reg <= 2'h0;
      rx_valid_reg <= 1'b0;
    end else begin
      buf_cnt_reg <= buf_cnt_next;
      rx_valid_reg <= buf_cnt_next != 2'h0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ent0_reg <= etwb_pkg::BYTE_RESET;
      ent1_reg <= etwb_pkg::BYTE_RESET;
    end else begin
      if (push && !wr_slot1) begin
        ent0_reg <= shift_reg;
      end else if (pop && (buf_cnt_reg == etwb_pkg::BUF_FULL)) begin
        ent0_reg <= ent1_reg;
      end
      if (push && wr_slot1) begin
        ent1_reg <= shift_reg;
      end
    end
  end

  // the clock line is input only
  assign SDA_O = sda_o_reg;
  assign SDA_OE = sda_oe_reg;
  assign RX_DATA = ent0_reg;
  assign RX_VALID = rx_valid_reg;
  assign TX_READY = tx_ready_reg;
  assign BUS_BUSY = busy_reg;
  assign START_SEEN = start_reg;
  assign STOP_SEEN = stop_reg;
  assign ADDRESSED = addressed_reg;
  assign READ_MODE = rw_reg;

endmodule

// ===== etwb_pkg.sv
// etwb_pkg: constants and state type of the two-wire bus slave front end
// assumes a 200 MHz system clock and an external bus master driving the clock line
package etwb_pkg;
  localparam int CLK_MHZ = 200;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_W = 4;
  localparam logic [SPIKE_W-1:0] SPIKE_CYC = SPIKE_W'(SPIKE_NS * CLK_MHZ / 1000);
  localparam int OUT_DLY_NS = 300;
  localparam int DLY_W = 7;
  localparam logic [DLY_W-1:0] OUT_DLY_CYC = DLY_W'((OUT_DLY_NS * CLK_MHZ + 999) / 1000);
  localparam int BYTE_W = 8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] CTRL_CODE = 4'hA;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic LINE_RESET = 1'b1;
  typedef enum logic [2:0] {ST_IDLE, ST_CTRL, ST_RX, ST_TX, ST_SKIP} etwb_state_e;
endpackage

// ===== etwb_front_end_chk.sv
// etwb_front_end_chk: port assertions for the two-wire bus slave front end
// assumes bind onto etwb_front_end, bus held idle-high at reset
`timescale 1ns/1ps
module etwb_front_end_chk (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic WRITE_BUSY,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_READY,
  input wire logic TX_READY,
  input wire logic BUS_BUSY,
  input wire logic START_SEEN,
  input wire logic STOP_SEEN,
  input wire logic ADDRESSED,
  input wire logic READ_MODE
);
  logic [7:0] fall_cnt_reg;
  logic [6:0] busy_cnt_reg;
  logic scl_reg;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // cycles since raw clock fall, and since write cycle began
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      fall_cnt_reg <= 8'hFF;
      busy_cnt_reg <= 7'h00;
      scl_reg <= 1'b1;
    end else begin
      scl_reg <= SCL_I;
      fall_cnt_reg <= (scl_reg && !SCL_I) ? 8'h00 : fall_cnt_reg + {7'h00, fall_cnt_reg != 8'hFF};
      busy_cnt_reg <= !WRITE_BUSY ? 7'h00 : busy_cnt_reg + {6'h00, busy_cnt_reg != 7'h7F};
    end
  end
  property p_sda_low; SDA_O == 1'b0; endproperty
  a_sda_low:
    assert property (p_sda_low) else $error("data pin driven high");
  // thirteen samples low is past the spike width, so the Start must come out
  property p_start_det;
    $fell(SDA_I) && SCL_I ##1 (SCL_I && !SDA_I) [*8] ##1 (SCL_I && !SDA_I) [*4] |-> ##[1:8] START_SEEN;
  endproperty
  a_start_det:
    assert property (p_start_det) else $error("start not reported");
  property p_stop_det;
    $rose(SDA_I) && SCL_I && BUS_BUSY ##1 (SCL_I && SDA_I) [*8] ##1 (SCL_I && SDA_I) [*4] |-> ##[1:8] STOP_SEEN;
  endproperty
  a_stop_det:
    assert property (p_stop_det) else $error("stop not reported");
  property p_stop_idle; STOP_SEEN |=> !BUS_BUSY && !ADDRESSED; endproperty
  a_stop_idle:
    assert property (p_stop_idle) else $error("bus not idle after stop");
  property p_oe_delay; $changed(SDA_OE) && !SCL_I |-> fall_cnt_reg >= 8'h3C; endproperty
  a_oe_delay:
    assert property (p_oe_delay) else $error("data changed too soon after clock fall");
  property p_oe_clk_low; $rose(SDA_OE) |-> !SCL_I; endproperty
  a_oe_clk_low:
    assert property (p_oe_clk_low) else $error("data pulled during clock high");
  property p_busy_noack; busy_cnt_reg >= 7'h64 && !(ADDRESSED && READ_MODE) |-> !$rose(SDA_OE); endproperty
  a_busy_noack:
    assert property (p_busy_noack) else $error("ack during write cycle");
  property p_tx_role; TX_READY |-> ADDRESSED && READ_MODE; endproperty
  a_tx_role:
    assert property (p_tx_role) else $error("fetch outside read");
  property p_rx_hold; RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA); endproperty
  a_rx_hold:
    assert property (p_rx_hold) else $error("receive word lost");
endmodule

// ===== etwb_bus_master.sv
// etwb_bus_master: behavioural two-wire bus master, own 64 ns tick
// assumes the bench builds the pulled-up data wire from all pull-downs
`timescale 1ns/1ps
module etwb_bus_master (
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  logic lclk;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    lclk = 1'b0;
    #7;
    forever #32 lclk = ~lclk;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge lclk);
  endtask
  // one bit per pulse, data moved only in clock low
  task automatic bitx(input logic b, output logic r);
    tk(2);
    sda_low = !b;
    tk(14);
    scl = 1'b1;
    tk(4);
    r = sda;
    tk(4);
    scl = 1'b0;
  endtask
  task automatic start();
    tk(2);
    sda_low = 1'b0;
    tk(14);
    scl = 1'b1;
    tk(8);
    sda_low = 1'b1;
    tk(8);
    scl = 1'b0;
  endtask
  task automatic stop();
    tk(2);
    sda_low = 1'b1;
    tk(14);
    scl = 1'b1;
    tk(8);
    sda_low = 1'b0;
    tk(16);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, ack);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask
endmodule

// ===== etwb_front_end_tb.sv
// etwb_front_end_tb: self-checking bench for the bus slave front end
// assumes etwb_bus_master on the far side and the checker bound below
`timescale 1ns/1ps
module etwb_front_end_tb;
  logic clk, rst_n, wr_busy, rx_rdy, tx_vld, spk, ack, sda_o, sda_oe, rx_valid, tx_ready;
  logic bus_busy, start_seen, stop_seen, addressed, read_mode, scl, m_low;
  logic [7:0] tx_d, rd, rx_data;
  int num_errors = 0, total_checks = 0, n_start = 0, s0, n_stop = 0, s1;
  wire sda = !(m_low || spk || (sda_oe && !sda_o));
  etwb_front_end i_etwb_front_end (.CLK_SYS(clk), .RST_N(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .WRITE_BUSY(wr_busy), .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_rdy),
    .TX_DATA(tx_d), .TX_VALID(tx_vld), .TX_READY(tx_ready), .BUS_BUSY(bus_busy), .START_SEEN(start_seen),
    .STOP_SEEN(stop_seen), .ADDRESSED(addressed), .READ_MODE(read_mode));
  etwb_bus_master i_etwb_bus_master (.sda(sda), .scl(scl), .sda_low(m_low));
  always @(posedge clk) if (start_seen === 1'b1) n_start <= n_start + 1;
  always @(posedge clk) if (stop_seen === 1'b1) n_stop <= n_stop + 1;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic [7:0] d, input logic e);
    i_etwb_bus_master.wbyte(d, ack);
    chk("ack", {7'h00, e}, {7'h00, ack});
  endtask
  task automatic pop(input logic [7:0] e);
    chk("rx valid", 8'h01, {7'h00, rx_valid});
    chk("rx data", e, rx_data);
    @(posedge clk) rx_rdy <= 1'b1;
    @(posedge clk) rx_rdy <= 1'b0;
    #1;
  endtask
  task automatic s_spike();
    s0 = n_start;
    @(posedge clk) spk <= 1'b1;
    repeat (8) @(posedge clk);
    spk <= 1'b0;
    repeat (40) @(posedge clk);
    chk("spike start", 8'h00, 8'(n_start - s0));
    chk("spike busy", 8'h00, {7'h00, bus_busy});
  endtask
  task automatic s_write();
    s0 = n_start;
    s1 = n_stop;
    i_etwb_bus_master.start();
    chk("starts", 8'h01, 8'(n_start - s0));
    wb(8'hA0, 1'b0);
    chk("addressed", 8'h01, {7'h00, addressed});
    chk("read mode", 8'h00, {7'h00, read_mode});
    wb(8'h5C, 1'b0);
    wb(8'h3A, 1'b0);
    wb(8'h77, 1'b1);
    i_etwb_bus_master.stop();
    chk("busy", 8'h00, {7'h00, bus_busy});
    chk("stops", 8'h01, 8'(n_stop - s1));
    pop(8'h5C);
    pop(8'h3A);
    chk("rx empty", 8'h00, {7'h00, rx_valid});
  endtask
  task automatic s_read();
    @(posedge clk);
    tx_d <= 8'h96;
    tx_vld <= 1'b1;
    i_etwb_bus_master.start();
    wb(8'hA7, 1'b0);
    chk("read mode", 8'h01, {7'h00, read_mode});
    for (int i = 0; i < 200 && tx_ready !== 1'b1; i++) @(posedge clk) #1;
    chk("tx fetch", 8'h01, {7'h00, tx_ready});
    @(posedge clk) tx_vld <= 1'b0;
    i_etwb_bus_master.rbyte(1'b0, rd);
    chk("rd 1", 8'h96, rd);
    i_etwb_bus_master.rbyte(1'b1, rd);
    chk("rd 2", 8'hFF, rd);
    @(posedge clk);
    tx_d <= 8'h00;
    tx_vld <= 1'b1;
    i_etwb_bus_master.tk(10);
    chk("released", 8'h00, {7'h00, sda_oe});
    i_etwb_bus_master.stop();
    chk("addressed", 8'h00, {7'h00, addressed});
  endtask
  task automatic s_bad();
    i_etwb_bus_master.start();
    wb(8'h50, 1'b1);
    chk("addressed", 8'h00, {7'h00, addressed});
    @(posedge clk) wr_busy <= 1'b1;
    i_etwb_bus_master.start();
    wb(8'hA0, 1'b1);
    i_etwb_bus_master.stop();
    @(posedge clk) wr_busy <= 1'b0;
    i_etwb_bus_master.start();
    wb(8'hA0, 1'b0);
    for (int i = 0; i < 3; i++) i_etwb_bus_master.bitx(1'b1, ack);
    i_etwb_bus_master.stop();
    chk("partial", 8'h00, {7'h00, rx_valid});
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    wr_busy = 1'b0;
    rx_rdy = 1'b0;
    tx_vld = 1'b0;
    tx_d = 8'h00;
    spk = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge clk);
    s_spike();
    s_write();
    s_read();
    s_bad();
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule
bind etwb_front_end etwb_front_end_chk i_etwb_front_end_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SCL_I(SCL_I),
  .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .WRITE_BUSY(WRITE_BUSY), .RX_DATA(RX_DATA),
  .RX_VALID(RX_VALID), .RX_READY(RX_READY), .TX_READY(TX_READY), .BUS_BUSY(BUS_BUSY),
  .START_SEEN(START_SEEN), .STOP_SEEN(STOP_SEEN), .ADDRESSED(ADDRESSED), .READ_MODE(READ_MODE));
